// ==== design/lcdio_pkg.sv ====
// lcdio_pkg: register map, reset values and carrier types for the lcd-shared io ports
// assumes a cpu register port addressed by a 9-bit banked data-memory address
package lcdio_pkg;
  localparam int ADDR_W = 9;
  localparam logic [8:0] OFF_C_DATA = 9'h0_07;
  localparam logic [8:0] OFF_D_DATA = 9'h0_08;
  localparam logic [8:0] OFF_E_DATA = 9'h0_09;
  localparam logic [8:0] OFF_C_DIR = 9'h0_87;
  localparam logic [8:0] OFF_D_DIR = 9'h0_88;
  localparam logic [8:0] OFF_E_DIR = 9'h0_89;
  localparam logic [8:0] OFF_F_DATA = 9'h0_107;
  localparam logic [8:0] OFF_SEG_EN = 9'h0_10d;
  localparam logic [8:0] OFF_F_DIR = 9'h0_187;
  localparam logic [7:0] RST_C_DIR = 8'h3f;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_SEG_EN = 8'hff;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] C_IMPL_MASK = 8'h3f;
  localparam logic [7:0] D_BIDIR_MASK = 8'h1f;
  // segment-enable bit positions
  localparam int SE_FIRST = 0;
  localparam int SE_G5 = 1;
  localparam int SE_G9 = 2;
  localparam int SE_G12 = 3;
  localparam int SE_G16 = 4;
  localparam int SE_G20 = 5;
  localparam int SE_G27 = 6;
  localparam int SE_UPPER_COM = 7;

  typedef struct packed {
    logic [7:0] c;
    logic [7:0] d;
    logic [7:0] e;
    logic [7:0] f;
  } lcdio_pins_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } lcdio_req_t;
endpackage

// ==== design/lcdio_ports.sv ====
// lcdio_ports: port groups c (6-bit bidir), d (5 bidir + 3 in), e and f (input only); d, e and f shared with lcd
// assumes pin inputs are already synchronous to i_mclk; the lcd driver consumes o_lcd_own
// Behaviour
// - group c pins 0..2 carry timer oscillator/clock and capture-compare-pwm functions
// - group c pins 3..5 carry serial clock, serial data in, serial data out
// - group c data and direction bits 7 and 6 always read zero
// - group c latch undefined at power-on, kept otherwise; direction resets to ones
// - group d pins 0..4 are bidirectional io or lcd segments 00..04
// - group d pins 5..7 are inputs, segments 29..31 or commons 3..1
// - group d direction drives enables only for pins 0..4 in digital use
// - power-on reset puts all lcd-shared pins in segment mode, enables all ones
// - a set segment-enable bit overrides direction, lcd keeps the pin
// - group e is input only; pins 0..6 share segments 05..11
// - group e pin 7 shares segment 27, absent on the small package
// - group f is input only; pins 0..7 share segments 12..19
// - direction one floats the driver, zero drives the output latch
// - reading a port returns pins, writing updates the output latch
`timescale 1ns/10ps
module lcdio_ports #(
  parameter bit HAS_E7 = 1'b1
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_por,
  input wire lcdio_pkg::lcdio_req_t i_req,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  input wire lcdio_pkg::lcdio_pins_t i_pin,
  output lcdio_pkg::lcdio_pins_t o_pin,
  output lcdio_pkg::lcdio_pins_t o_pin_oe_n,
  output lcdio_pkg::lcdio_pins_t o_lcd_own,
  input wire logic [5:0] i_c_periph_en,
  input wire logic [5:0] i_c_periph_out,
  input wire logic [5:0] i_c_periph_oe_n,
  output logic [5:0] o_c_periph_in
);
  logic [7:0] c_latch_q, d_latch_q;
  logic [7:0] c_dir_q, d_dir_q, e_dir_q, f_dir_q;
  logic [7:0] seg_en_q;
  logic [7:0] rdata_d;
  logic rvalid_d;
  logic [7:0] own_d, own_e, own_f;

  function automatic logic wr_hit(input lcdio_pkg::lcdio_req_t r, input logic [8:0] off);
    wr_hit = r.wr && (r.addr == off);
  endfunction

  // group c latch: no async reset so other resets leave it unchanged and power-on leaves it undefined
  always_ff @(posedge i_mclk) begin
    if (wr_hit(i_req, lcdio_pkg::OFF_C_DATA)) begin
      c_latch_q <= i_req.wdata & lcdio_pkg::C_IMPL_MASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c_dir_q <= lcdio_pkg::RST_C_DIR;
    end else if (wr_hit(i_req, lcdio_pkg::OFF_C_DIR)) begin
      c_dir_q <= i_req.wdata & lcdio_pkg::C_IMPL_MASK;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      d_latch_q <= lcdio_pkg::RST_LATCH;
    end else if (wr_hit(i_req, lcdio_pkg::OFF_D_DATA)) begin
      d_latch_q <= i_req.wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      d_dir_q <= lcdio_pkg::RST_DIR;
      e_dir_q <= lcdio_pkg::RST_DIR;
      f_dir_q <= lcdio_pkg::RST_DIR;
    end else begin
      if (wr_hit(i_req, lcdio_pkg::OFF_D_DIR)) begin
        d_dir_q <= i_req.wdata;
      end
      if (wr_hit(i_req, lcdio_pkg::OFF_E_DIR)) begin
        e_dir_q <= i_req.wdata;
      end
      if (wr_hit(i_req, lcdio_pkg::OFF_F_DIR)) begin
        f_dir_q <= i_req.wdata;
      end
    end
  end

  // segment enables also return to ones on a power-on request while running
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seg_en_q <= lcdio_pkg::RST_SEG_EN;
    end else if (i_por) begin
      seg_en_q <= lcdio_pkg::RST_SEG_EN;
    end else if (wr_hit(i_req, lcdio_pkg::OFF_SEG_EN)) begin
      seg_en_q <= i_req.wdata;
    end
  end

  // ownership map: which enable bit owns which pin by segment number
  always_comb begin
    own_d = {{3{seg_en_q[lcdio_pkg::SE_UPPER_COM]}}, {5{seg_en_q[lcdio_pkg::SE_FIRST]}}};
    own_e = {seg_en_q[lcdio_pkg::SE_G27] | ~HAS_E7, {3{seg_en_q[lcdio_pkg::SE_G9]}},
             {4{seg_en_q[lcdio_pkg::SE_G5]}}};
    own_f = {{4{seg_en_q[lcdio_pkg::SE_G16]}}, {4{seg_en_q[lcdio_pkg::SE_G12]}}};
  end

  // pin drive; enables are active low, peripheral overrides direction on group c
  always_comb begin
    o_lcd_own = '{c: 8'h00, d: own_d, e: own_e, f: own_f};
    o_pin.c = {2'b00, 6'(i_c_periph_en & i_c_periph_out) | 6'(~i_c_periph_en & c_latch_q[5:0])};
    o_pin.d = d_latch_q & lcdio_pkg::D_BIDIR_MASK;
    o_pin.e = 8'h00;
    o_pin.f = 8'h00;
    o_pin_oe_n.c = {2'b11, (i_c_periph_en & i_c_periph_oe_n) | (~i_c_periph_en & c_dir_q[5:0])};
    o_pin_oe_n.d = d_dir_q | ~lcdio_pkg::D_BIDIR_MASK | own_d;
    o_pin_oe_n.e = 8'hff;
    o_pin_oe_n.f = 8'hff;
    o_c_periph_in = i_pin.c[5:0];
  end

  // register reads return live pin levels for the port registers
  always_comb begin
    rdata_d = 8'h00;
    rvalid_d = i_req.rd;
    unique case (i_req.addr)
      lcdio_pkg::OFF_C_DATA: rdata_d = i_pin.c & lcdio_pkg::C_IMPL_MASK;
      lcdio_pkg::OFF_D_DATA: rdata_d = i_pin.d;
      lcdio_pkg::OFF_E_DATA: rdata_d = i_pin.e;
      lcdio_pkg::OFF_F_DATA: rdata_d = i_pin.f;
      lcdio_pkg::OFF_C_DIR: rdata_d = c_dir_q & lcdio_pkg::C_IMPL_MASK;
      lcdio_pkg::OFF_D_DIR: rdata_d = d_dir_q;
      lcdio_pkg::OFF_E_DIR: rdata_d = e_dir_q;
      lcdio_pkg::OFF_F_DIR: rdata_d = f_dir_q;
      lcdio_pkg::OFF_SEG_EN: rdata_d = seg_en_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rdata <= rvalid_d ? rdata_d : 8'h00;
      o_rvalid <= rvalid_d;
    end
  end
endmodule // lcdio_ports

// ==== bench/lcdio_ports_sva.sv ====
// lcdio_ports_sva: port checks for the lcd-shared io block
// assumes default HAS_E7 and the registered read path
`timescale 1ns/10ps
module lcdio_ports_sva (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_por,
  input wire lcdio_pkg::lcdio_req_t i_req,
  input wire logic [7:0] o_rdata,
  input wire logic o_rvalid,
  input wire lcdio_pkg::lcdio_pins_t i_pin,
  input wire lcdio_pkg::lcdio_pins_t o_pin_oe_n,
  input wire lcdio_pkg::lcdio_pins_t o_lcd_own
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  property p_rv; i_req.rd |=> o_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("no rvalid");
  property p_rd; i_req.rd && i_req.addr == 9'h008 |=> o_rdata == $past(i_pin.d); endproperty
  a_rd: assert property (p_rd) else $error("bad d read");
  property p_top; i_req.rd && (i_req.addr == 9'h007 || i_req.addr == 9'h087) |=> o_rdata[7:6] == 2'h0; endproperty
  a_top: assert property (p_top) else $error("c top set");
  property p_ef; o_pin_oe_n.e == 8'hff && o_pin_oe_n.f == 8'hff; endproperty
  a_ef: assert property (p_ef) else $error("e f driven");
  property p_din; o_pin_oe_n.d[7:5] == 3'h7; endproperty
  a_din: assert property (p_din) else $error("d top driven");
  property p_own; (o_lcd_own.d & ~o_pin_oe_n.d) == 8'h00; endproperty
  a_own: assert property (p_own) else $error("lcd pin driven");
  property p_por; i_por |=> o_lcd_own == 32'h00ff_ffff; endproperty
  a_por: assert property (p_por) else $error("por own");
  property p_dd; i_req.wr && i_req.addr == 9'h088 && !o_lcd_own.d[0] && !i_por |=> o_pin_oe_n.d[4:0] == $past(i_req.wdata[4:0]); endproperty
  a_dd: assert property (p_dd) else $error("d dir");
endmodule // lcdio_ports_sva
bind lcdio_ports lcdio_ports_sva u_sva (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_por(i_por), .i_req(i_req),
  .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_pin(i_pin), .o_pin_oe_n(o_pin_oe_n), .o_lcd_own(o_lcd_own));

// ==== bench/lcdio_pin_model.sv ====
// lcdio_pin_model: board pins around the io block
// assumes the bench gives each pin's outside level
`timescale 1ns/10ps
module lcdio_pin_model (
  input wire lcdio_pkg::lcdio_pins_t i_drv,
  input wire lcdio_pkg::lcdio_pins_t i_oe_n,
  input wire lcdio_pkg::lcdio_pins_t i_ext,
  output lcdio_pkg::lcdio_pins_t o_lvl
);
  // a released pin shows the outside level, never the last driven one
  assign o_lvl = (i_drv & ~i_oe_n) | (i_ext & i_oe_n);
endmodule // lcdio_pin_model

// ==== bench/lcdio_ports_tb.sv ====
// lcdio_ports_tb: register and pin checks
// assumes the pin model closes the pin loop
`timescale 1ns/10ps
module lcdio_ports_tb;
  typedef struct packed {logic w; logic [8:0] a; logic [7:0] d; logic [7:0] e;} lcdio_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic por = 1'b1;
  lcdio_pkg::lcdio_req_t req = '0;
  lcdio_pkg::lcdio_pins_t pin, drv, oe_n, own;
  lcdio_pkg::lcdio_pins_t ext = 32'h5ca3_3cc5;
  logic [7:0] rdata;
  logic rvalid;
  logic [5:0] c_en = 6'h00;
  logic [5:0] c_out = 6'h00;
  logic [5:0] c_oe_n = 6'h3f;
  logic [5:0] c_in;
  int miscompares = 0;
  int n_checks = 0;
  lcdio_row_t rows [12] = '{'{0, 9'h087, 0, 8'h3f}, '{0, 9'h088, 0, 8'hff}, '{0, 9'h10d, 0, 8'hff},
    '{0, 9'h00a, 0, 8'h00}, '{1, 9'h087, 8'hff, 8'h3f}, '{1, 9'h10d, 8'h00, 8'h00}, '{1, 9'h088, 8'he0, 8'he0},
    '{1, 9'h008, 8'h15, 8'hb5}, '{0, 9'h009, 0, 8'h3c}, '{0, 9'h107, 0, 8'hc5}, '{1, 9'h087, 8'h00, 8'h00},
    '{1, 9'h007, 8'h2a, 8'h2a}};
  always #5 clk = ~clk;
  lcdio_ports dut (.i_mclk(clk), .i_rst_n(rst_n), .i_por(por), .i_req(req), .o_rdata(rdata), .o_rvalid(rvalid),
    .i_pin(pin), .o_pin(drv), .o_pin_oe_n(oe_n), .o_lcd_own(own), .i_c_periph_en(c_en),
    .i_c_periph_out(c_out), .i_c_periph_oe_n(c_oe_n), .o_c_periph_in(c_in));
  lcdio_pin_model u_pins (.i_drv(drv), .i_oe_n(oe_n), .i_ext(ext), .o_lvl(pin));
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      $display("mismatch at %0t got %h exp %h", $time, g, e);
      miscompares++;
    end
  endtask
  task automatic acc(input logic w, input logic [8:0] a, input logic [7:0] d, input logic [7:0] e);
    if (w) @(posedge clk) req <= {1'b1, 1'b0, a, d};
    @(posedge clk) req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clk) req <= '0;
    #1 cmp(rdata, e);
    cmp({7'h00, rvalid}, 8'h01);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    por <= 1'b0;
    foreach (rows[k]) begin
      acc(rows[k].w, rows[k].a, rows[k].d, rows[k].e);
      $display("row %0d done", k);
    end
    acc(1'b1, 9'h10d, 8'h00, 8'h00);
    @(posedge clk) por <= 1'b1;
    @(posedge clk) por <= 1'b0;
    #1 cmp(oe_n.d, 8'hff);
    cmp(own.e, 8'hff);
    $display("power-on override done");
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    acc(1'b1, 9'h087, 8'h00, 8'h00);
    acc(1'b0, 9'h007, 8'h00, 8'h2a);
    $display("latch keep done");
    // timer pin 0 taken over by its peripheral while the direction says input
    @(posedge clk) begin
      c_en <= 6'h01;
      c_out <= 6'h01;
      c_oe_n <= 6'h3e;
    end
    acc(1'b1, 9'h087, 8'h3f, 8'h3f);
    acc(1'b0, 9'h007, 8'h00, 8'h1d);
    cmp({2'b00, c_in}, 8'h1d);
    cmp(oe_n.c, 8'hfe);
    $display("peripheral override done");
    close_out();
  end
  initial begin
    #20000;
    miscompares++;
    close_out();
  end
endmodule // lcdio_ports_tb
